// >>> sim/pmdis_top_test.sv
`timescale 1ns/1ps
module pmdis_top_test;
	// dma channel zero is left out of this variant so the presence mask is exercised
	localparam pmdis_pkg::pmdis_mods_t PRESENT = 21'h1FFF7F;
	logic CLK, RESETN, HSEL, HWRITE, HREADY, HREADYOUT, HRESP;
	logic [31:0] HADDR, HWDATA, HRDATA, rd_val, seed;
	logic [1:0] HTRANS;
	logic [2:0] HSIZE;
	logic [20:0] GATE_REQ, MOD_EN;
	pmdis_pkg::pmdis_bank_t shadow;
	logic [15:0] mask [6];
	logic [7:0] addr [6];
	logic [31:0] exp_q [$];
	int errors, check_count, cycles, s;
	event rd_ev;
	assign HREADY = HREADYOUT;

	pmdis_top #(.MOD_PRESENT(PRESENT)) uut (.CLK(CLK), .RESETN(RESETN), .HSEL(HSEL),
		.HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
		.HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
		.GATE_REQ(GATE_REQ), .MOD_EN(MOD_EN));

	initial begin
		CLK = 1'b0;
		forever #12.5 CLK = ~CLK;
	end

	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] x;
		x = v ^ (v << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs

	// gate vector worked out from the bit map of each register
	function automatic logic [20:0] exp_gate(input pmdis_pkg::pmdis_bank_t b);
		return {b[5][13], b[5][11], b[5][8], b[5][5:2], b[5][1], b[4][8], b[4][3],
			b[3][11:8], b[2][3], b[1][7], b[1][3], b[0][3:0]};
	endfunction : exp_gate

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic complete_run;
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : complete_run

	task automatic wait_ready;
		@(posedge CLK);
		while (HREADY !== 1'b1) @(posedge CLK);
	endtask : wait_ready

	task automatic bus(input logic [7:0] a, input logic wr, input logic [2:0] sz,
		input logic [31:0] d);
		@(posedge CLK);
		HSEL <= 1'b1;
		HTRANS <= 2'h2;
		HADDR <= {24'h000000, a};
		HWRITE <= wr;
		HSIZE <= sz;
		wait_ready();
		HSEL <= 1'b0;
		HTRANS <= 2'h0;
		HWDATA <= d;
		wait_ready();
		if (!wr) begin
			rd_val = HRDATA;
			->rd_ev;
		end
	endtask : bus

	task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(a, 1'b0, pmdis_pkg::PMDIS_HSIZE_WORD, 32'h00000000);
	endtask : rd_reg

	task automatic wr_reg(input int k, input logic [31:0] d);
		logic [20:0] old;
		old = exp_gate(shadow);
		bus(addr[k], 1'b1, pmdis_pkg::PMDIS_HSIZE_WORD, d);
		shadow[k] = d[15:0] & mask[k];
		#1;
		chk("gate held", 32'(GATE_REQ), 32'(old));
		@(posedge CLK);
		#1;
		chk("gate", 32'(GATE_REQ), 32'(exp_gate(shadow)));
		chk("enable", 32'(MOD_EN), 32'(~exp_gate(shadow) & PRESENT));
		rd_reg(addr[k], {16'h0000, shadow[k]});
	endtask : wr_reg

	initial begin
		forever begin
			@(rd_ev);
			chk("read data", rd_val, exp_q.pop_front());
		end
	end

	always @(posedge CLK) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			$display("Error timeout expected 20000 cycles seen more");
			complete_run();
		end
	end

	initial begin
		{RESETN, HSEL, HWRITE, HTRANS, HSIZE, HADDR, HWDATA} = '0;
		{errors, check_count, cycles} = '0;
		seed = 32'h0000F38A;
		shadow = '0;
		mask = '{pmdis_pkg::PMDIS_MASK_CTRL2, pmdis_pkg::PMDIS_MASK_CTRL3,
			pmdis_pkg::PMDIS_MASK_CTRL4, pmdis_pkg::PMDIS_MASK_CTRL6,
			pmdis_pkg::PMDIS_MASK_CTRL7, pmdis_pkg::PMDIS_MASK_CTRL8};
		addr = '{8'h08, 8'h0C, 8'h10, 8'h18, 8'h1C, 8'h20};
		repeat (16) @(posedge CLK);
		RESETN <= 1'b1;
		#1;
		chk("reset gate", 32'(GATE_REQ), 32'h00000000);
		chk("reset enable", 32'(MOD_EN), 32'(PRESENT));
		for (int k = 0; k < 6; k++) rd_reg(addr[k], 32'h00000000);
		$display("test reset values done");
		for (int k = 0; k < 6; k++) wr_reg(k, 32'hFFFFFFFF);
		for (int k = 0; k < 6; k++) wr_reg(k, 32'h00000000);
		$display("test set and clear done");
		// unmapped place and a halfword write must leave everything alone
		bus(8'h04, 1'b1, pmdis_pkg::PMDIS_HSIZE_WORD, 32'hFFFFFFFF);
		rd_reg(8'h04, 32'h00000000);
		bus(addr[5], 1'b1, 3'h1, 32'h0000FFFF);
		rd_reg(addr[5], 32'h00000000);
		chk("response", 32'(HRESP), 32'h00000000);
		$display("test refused writes done");
		repeat (40) begin
			seed = xs(seed);
			s = seed % 6;
			seed = xs(seed);
			wr_reg(s, seed);
		end
		$display("test random writes done");
		wr_reg(5, 32'hFFFFFFFF);
		@(posedge CLK);
		RESETN <= 1'b0;
		repeat (2) @(posedge CLK);
		RESETN <= 1'b1;
		shadow = '0;
		#1;
		chk("rerun gate", 32'(GATE_REQ), 32'h00000000);
		for (int k = 0; k < 6; k++) rd_reg(addr[k], 32'h00000000);
		$display("test second reset done");
		complete_run();
	end
endmodule : pmdis_top_test

// >>> src/pmdis_gate.sv
`timescale 1ns/1ps
module pmdis_gate #(
	parameter pmdis_pkg::pmdis_mods_t MOD_PRESENT = '1
) (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// bank in, requests out
	pmdis_gate_if.gater bus
);

	typedef struct packed {
		pmdis_pkg::pmdis_mods_t gate;
		pmdis_pkg::pmdis_mods_t en;
	} pmdis_gst_s;

	pmdis_gst_s st_q;
	pmdis_gst_s st_d;

	// one register stage: the gate follows a write by one cycle
	always_comb begin
		st_d.gate = pmdis_pkg::pmdis_pack(bus.dis);
		st_d.en = ~st_d.gate & MOD_PRESENT;
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			// every present module comes out of reset running
			st_q.gate <= '0;
			st_q.en <= MOD_PRESENT;
		end else begin
			st_q <= st_d;
		end
	end

	assign bus.gate = st_q.gate;
	assign bus.en = st_q.en;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence s_cap_set;
		$rose(bus.dis[pmdis_pkg::PMDIS_SLOT_CTRL2][pmdis_pkg::PMDIS_B_CAPTURE_LO]);
	endsequence

	a_capture_map: assert property (
		##1 bus.gate[pmdis_pkg::PMDIS_M_CAPTURE_LO +: 4]
			== $past(bus.dis[pmdis_pkg::PMDIS_SLOT_CTRL2][3:0]))
		else $error("capture unit gate mismatch");
	a_crc_uart_map: assert property (
		##1 bus.gate[pmdis_pkg::PMDIS_M_CHECKSUM] == $past(bus.dis[1][7])
			&& bus.gate[pmdis_pkg::PMDIS_M_SERIAL_PORT3] == $past(bus.dis[1][3]))
		else $error("checksum or serial port gate mismatch");
	a_refclk_map: assert property (
		##1 bus.gate[pmdis_pkg::PMDIS_M_REF_CLOCK_OUT] == $past(bus.dis[2][3]))
		else $error("reference clock gate mismatch");
	a_dma_map: assert property (
		##1 bus.gate[pmdis_pkg::PMDIS_M_DMA_LO +: 4] == $past(bus.dis[3][11:8]))
		else $error("dma gate mismatch");
	a_cmp_ptg_map: assert property (
		##1 bus.gate[pmdis_pkg::PMDIS_M_COMPARATOR1] == $past(bus.dis[4][8])
			&& bus.gate[pmdis_pkg::PMDIS_M_TRIGGER_GEN] == $past(bus.dis[4][3]))
		else $error("comparator or trigger gate mismatch");
	a_misc8_map: assert property (
		##1 bus.gate[pmdis_pkg::PMDIS_M_OP_AMPS] == $past(bus.dis[5][13])
			&& bus.gate[pmdis_pkg::PMDIS_M_SENT_RX1] == $past(bus.dis[5][11])
			&& bus.gate[pmdis_pkg::PMDIS_M_DEADMAN] == $past(bus.dis[5][8]))
		else $error("op amp, sent or deadman gate mismatch");
	a_cell_map: assert property (
		##1 bus.gate[pmdis_pkg::PMDIS_M_CURRENT_SOURCE +: 5] == $past(bus.dis[5][5:1]))
		else $error("logic cell or current source gate mismatch");
	a_enable_rule: assert property (
		bus.en == (~bus.gate & MOD_PRESENT))
		else $error("enable not gated by presence");
	a_one_cycle_on: assert property (
		s_cap_set |-> !bus.gate[pmdis_pkg::PMDIS_M_CAPTURE_LO]
			##1 bus.gate[pmdis_pkg::PMDIS_M_CAPTURE_LO])
		else $error("disable did not land one cycle later");

endmodule : pmdis_gate

// >>> src/pmdis_gate_if.sv
`timescale 1ns/1ps
interface pmdis_gate_if;
	pmdis_pkg::pmdis_bank_t dis;
	pmdis_pkg::pmdis_mods_t gate;
	pmdis_pkg::pmdis_mods_t en;
	modport regs (output dis, input gate, input en);
	modport gater (input dis, output gate, output en);
endinterface : pmdis_gate_if

// >>> src/pmdis_pkg.sv
package pmdis_pkg;

	// register bank geometry
	localparam int unsigned PMDIS_NREG = 6;
	localparam int unsigned PMDIS_DW = 16;
	localparam int unsigned PMDIS_NMOD = 21;
	localparam int unsigned PMDIS_AW = 8;

	typedef logic [PMDIS_NREG-1:0][PMDIS_DW-1:0] pmdis_bank_t;
	typedef logic [PMDIS_NMOD-1:0] pmdis_mods_t;
	typedef logic [2:0] pmdis_slot_t;

	// bank slots, one per control register
	localparam pmdis_slot_t PMDIS_SLOT_CTRL2 = 3'h0;
	localparam pmdis_slot_t PMDIS_SLOT_CTRL3 = 3'h1;
	localparam pmdis_slot_t PMDIS_SLOT_CTRL4 = 3'h2;
	localparam pmdis_slot_t PMDIS_SLOT_CTRL6 = 3'h3;
	localparam pmdis_slot_t PMDIS_SLOT_CTRL7 = 3'h4;
	localparam pmdis_slot_t PMDIS_SLOT_CTRL8 = 3'h5;

	// byte addresses on the bus: four times the register number
	localparam logic [PMDIS_AW-1:0] PMDIS_ADDR_CTRL2 = 8'h08;
	localparam logic [PMDIS_AW-1:0] PMDIS_ADDR_CTRL3 = 8'h0C;
	localparam logic [PMDIS_AW-1:0] PMDIS_ADDR_CTRL4 = 8'h10;
	localparam logic [PMDIS_AW-1:0] PMDIS_ADDR_CTRL6 = 8'h18;
	localparam logic [PMDIS_AW-1:0] PMDIS_ADDR_CTRL7 = 8'h1C;
	localparam logic [PMDIS_AW-1:0] PMDIS_ADDR_CTRL8 = 8'h20;

	// implemented bits of each register
	localparam logic [PMDIS_DW-1:0] PMDIS_MASK_CTRL2 = 16'h000F;
	localparam logic [PMDIS_DW-1:0] PMDIS_MASK_CTRL3 = 16'h0088;
	localparam logic [PMDIS_DW-1:0] PMDIS_MASK_CTRL4 = 16'h0008;
	localparam logic [PMDIS_DW-1:0] PMDIS_MASK_CTRL6 = 16'h0F00;
	localparam logic [PMDIS_DW-1:0] PMDIS_MASK_CTRL7 = 16'h0108;
	localparam logic [PMDIS_DW-1:0] PMDIS_MASK_CTRL8 = 16'h293E;
	localparam logic [PMDIS_DW-1:0] PMDIS_RESET_VAL = 16'h0000;

	// field positions inside the registers
	localparam int unsigned PMDIS_B_CAPTURE_LO = 0;
	localparam int unsigned PMDIS_B_SERIAL_PORT3 = 3;
	localparam int unsigned PMDIS_B_CHECKSUM = 7;
	localparam int unsigned PMDIS_B_REF_CLOCK_OUT = 3;
	localparam int unsigned PMDIS_B_DMA_LO = 8;
	localparam int unsigned PMDIS_B_TRIGGER_GEN = 3;
	localparam int unsigned PMDIS_B_COMPARATOR1 = 8;
	localparam int unsigned PMDIS_B_CURRENT_SOURCE = 1;
	localparam int unsigned PMDIS_B_LOGIC_CELL_LO = 2;
	localparam int unsigned PMDIS_B_DEADMAN = 8;
	localparam int unsigned PMDIS_B_SENT_RX1 = 11;
	localparam int unsigned PMDIS_B_OP_AMPS = 13;

	// positions in the flat gate-request vector
	localparam int unsigned PMDIS_M_CAPTURE_LO = 0;
	localparam int unsigned PMDIS_M_SERIAL_PORT3 = 4;
	localparam int unsigned PMDIS_M_CHECKSUM = 5;
	localparam int unsigned PMDIS_M_REF_CLOCK_OUT = 6;
	localparam int unsigned PMDIS_M_DMA_LO = 7;
	localparam int unsigned PMDIS_M_TRIGGER_GEN = 11;
	localparam int unsigned PMDIS_M_COMPARATOR1 = 12;
	localparam int unsigned PMDIS_M_CURRENT_SOURCE = 13;
	localparam int unsigned PMDIS_M_LOGIC_CELL_LO = 14;
	localparam int unsigned PMDIS_M_DEADMAN = 18;
	localparam int unsigned PMDIS_M_SENT_RX1 = 19;
	localparam int unsigned PMDIS_M_OP_AMPS = 20;

	// bus encodings
	localparam logic [2:0] PMDIS_HSIZE_WORD = 3'h2;
	localparam logic [31:0] PMDIS_RDATA_NONE = 32'h00000000;

	function automatic logic [PMDIS_DW-1:0] pmdis_mask(input pmdis_slot_t s);
		unique case (s)
			PMDIS_SLOT_CTRL2: pmdis_mask = PMDIS_MASK_CTRL2;
			PMDIS_SLOT_CTRL3: pmdis_mask = PMDIS_MASK_CTRL3;
			PMDIS_SLOT_CTRL4: pmdis_mask = PMDIS_MASK_CTRL4;
			PMDIS_SLOT_CTRL6: pmdis_mask = PMDIS_MASK_CTRL6;
			PMDIS_SLOT_CTRL7: pmdis_mask = PMDIS_MASK_CTRL7;
			PMDIS_SLOT_CTRL8: pmdis_mask = PMDIS_MASK_CTRL8;
			default: pmdis_mask = PMDIS_RESET_VAL;
		endcase
	endfunction : pmdis_mask

	// returns {hit, slot}
	function automatic logic [3:0] pmdis_decode(input logic [PMDIS_AW-1:0] a);
		unique case (a)
			PMDIS_ADDR_CTRL2: pmdis_decode = {1'b1, PMDIS_SLOT_CTRL2};
			PMDIS_ADDR_CTRL3: pmdis_decode = {1'b1, PMDIS_SLOT_CTRL3};
			PMDIS_ADDR_CTRL4: pmdis_decode = {1'b1, PMDIS_SLOT_CTRL4};
			PMDIS_ADDR_CTRL6: pmdis_decode = {1'b1, PMDIS_SLOT_CTRL6};
			PMDIS_ADDR_CTRL7: pmdis_decode = {1'b1, PMDIS_SLOT_CTRL7};
			PMDIS_ADDR_CTRL8: pmdis_decode = {1'b1, PMDIS_SLOT_CTRL8};
			default: pmdis_decode = 4'h0;
		endcase
	endfunction : pmdis_decode

	function automatic pmdis_mods_t pmdis_pack(input pmdis_bank_t b);
		pmdis_mods_t m;
		m = '0;
		m[PMDIS_M_CAPTURE_LO +: 4] = b[PMDIS_SLOT_CTRL2][PMDIS_B_CAPTURE_LO +: 4];
		m[PMDIS_M_SERIAL_PORT3] = b[PMDIS_SLOT_CTRL3][PMDIS_B_SERIAL_PORT3];
		m[PMDIS_M_CHECKSUM] = b[PMDIS_SLOT_CTRL3][PMDIS_B_CHECKSUM];
		m[PMDIS_M_REF_CLOCK_OUT] = b[PMDIS_SLOT_CTRL4][PMDIS_B_REF_CLOCK_OUT];
		m[PMDIS_M_DMA_LO +: 4] = b[PMDIS_SLOT_CTRL6][PMDIS_B_DMA_LO +: 4];
		m[PMDIS_M_TRIGGER_GEN] = b[PMDIS_SLOT_CTRL7][PMDIS_B_TRIGGER_GEN];
		m[PMDIS_M_COMPARATOR1] = b[PMDIS_SLOT_CTRL7][PMDIS_B_COMPARATOR1];
		m[PMDIS_M_CURRENT_SOURCE] = b[PMDIS_SLOT_CTRL8][PMDIS_B_CURRENT_SOURCE];
		m[PMDIS_M_LOGIC_CELL_LO +: 4] = b[PMDIS_SLOT_CTRL8][PMDIS_B_LOGIC_CELL_LO +: 4];
		m[PMDIS_M_DEADMAN] = b[PMDIS_SLOT_CTRL8][PMDIS_B_DEADMAN];
		m[PMDIS_M_SENT_RX1] = b[PMDIS_SLOT_CTRL8][PMDIS_B_SENT_RX1];
		m[PMDIS_M_OP_AMPS] = b[PMDIS_SLOT_CTRL8][PMDIS_B_OP_AMPS];
		return m;
	endfunction : pmdis_pack

endpackage : pmdis_pkg

// >>> src/pmdis_top.sv
`timescale 1ns/1ps
// What this block does
// - control 2 bits 3..0 gate capture/compare timers four..one when set
// - control 3 bit 7 gates checksum unit, bit 3 gates serial port three
// - control 4 bit 3 gates the reference clock output
// - control 6 bits 11..8 gate dma channels three..zero
// - control 7 bit 8 gates comparator one, bit 3 the trigger generator
// - control 8 bits 5..2 logic cells four..one, bit 1 current source
// - unassigned bits ignore writes and read zero
// - assigned bits read and write, clear to zero at reset
// - a set bit stops every clock of its peripheral
// - a disabled peripheral ignores register writes, reads are invalid
// - a change takes effect one cycle after the write
module pmdis_top #(
	parameter pmdis_pkg::pmdis_mods_t MOD_PRESENT = '1
) (
	// clock and reset
	input wire logic CLK,
	input wire logic RESETN,
	// ahb-lite slave
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	// peripheral gating
	output logic [pmdis_pkg::PMDIS_NMOD-1:0] GATE_REQ,
	output logic [pmdis_pkg::PMDIS_NMOD-1:0] MOD_EN
);

	typedef struct packed {
		pmdis_pkg::pmdis_bank_t bank;
		logic dp_wr;
		logic dp_hit;
		pmdis_pkg::pmdis_slot_t dp_slot;
		logic [31:0] rdata;
	} pmdis_st_s;

	pmdis_st_s st_q;
	pmdis_st_s st_d;

	logic acc;
	logic [3:0] dec;
	logic a_hit;
	pmdis_pkg::pmdis_slot_t a_slot;

	pmdis_gate_if gif ();

	assign acc = HSEL && HREADY && HTRANS[1];
	assign dec = pmdis_pkg::pmdis_decode(HADDR[pmdis_pkg::PMDIS_AW-1:0]);
	assign a_hit = dec[3];
	assign a_slot = dec[2:0];

	always_comb begin
		st_d = st_q;
		// data phase of a write: only implemented bits are stored
		if (st_q.dp_wr && st_q.dp_hit) begin
			st_d.bank[st_q.dp_slot] = HWDATA[15:0] & pmdis_pkg::pmdis_mask(st_q.dp_slot);
		end
		// address phase; sub-word writes are dropped, there are no byte lanes here
		st_d.dp_wr = acc && HWRITE && (HSIZE == pmdis_pkg::PMDIS_HSIZE_WORD);
		st_d.dp_hit = acc && a_hit;
		st_d.dp_slot = a_slot;
		// read data taken from the next bank, so a write right before is forwarded
		if (acc && !HWRITE) begin
			if (a_hit) begin
				st_d.rdata = {16'h0000, st_d.bank[a_slot]};
			end else begin
				st_d.rdata = pmdis_pkg::PMDIS_RDATA_NONE;
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// zero wait states, never an error; unmapped reads return zero
	assign HREADYOUT = 1'b1;
	assign HRESP = 1'b0;
	assign HRDATA = st_q.rdata;

	assign gif.dis = st_q.bank;

	pmdis_gate #(
		.MOD_PRESENT(MOD_PRESENT)
	) u_gate (
		.clk(CLK),
		.resetn(RESETN),
		.bus(gif)
	);

	// peripherals use MOD_EN to block their own register access
	assign GATE_REQ = gif.gate;
	assign MOD_EN = gif.en;

	sequence s_wr_req;
		acc && HWRITE && (HSIZE == pmdis_pkg::PMDIS_HSIZE_WORD) && a_hit;
	endsequence

	sequence s_rd_req;
		acc && !HWRITE;
	endsequence

	a_write_lands: assert property (@(posedge CLK) disable iff (!RESETN)
		s_wr_req ##1 1 |=> st_q.bank[$past(a_slot, 2)]
			== ($past(HWDATA[15:0]) & pmdis_pkg::pmdis_mask($past(a_slot, 2))))
		else $error("written value not stored");
	a_read_answer: assert property (@(posedge CLK) disable iff (!RESETN)
		s_rd_req ##0 a_hit |=> HRDATA == {16'h0000, st_q.bank[$past(a_slot)]})
		else $error("read data does not match register");
	a_unimpl_zero: assert property (@(posedge CLK) disable iff (!RESETN)
		s_rd_req |=> HRDATA[31:16] == 16'h0000
			&& (HRDATA[15:0] & ~pmdis_pkg::pmdis_mask($past(a_slot))) == 16'h0000)
		else $error("unimplemented bit reads nonzero");
	a_reset_clear: assert property (@(posedge CLK)
		!RESETN |=> st_q.bank == '0 && GATE_REQ == '0 && HRDATA == 32'h00000000)
		else $error("reset did not clear state");
	a_gate_after_write: assert property (@(posedge CLK) disable iff (!RESETN)
		s_wr_req ##1 1 |=> ##1 GATE_REQ == pmdis_pkg::pmdis_pack($past(st_q.bank)))
		else $error("gate request not one cycle after store");
	a_bus_okay: assert property (@(posedge CLK) disable iff (!RESETN)
		HREADYOUT && !HRESP)
		else $error("slave stalled or errored");

endmodule : pmdis_top
